// file: logic/can_i2c_port_sharing_ctrl.sv
// pin sharing of four port-four pads among two can controllers and i2c
// assumes control inputs come from logic on I_SYS_CLK; I_PIN_IN is asynchronous
module can_i2c_port_sharing_ctrl
  import cips_pkg::*;
#(
  parameter logic [cips_pkg::ADDR_W-1:0] CAN_BASE = cips_pkg::CAN_BASE_DEF
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // extension peripheral control and system config
  input wire logic I_PERCTL_WR,
  input wire cips_pkg::cips_perctl_t I_PERCTL_DATA,
  input wire logic I_GLOBAL_ENABLE,
  input wire logic I_MISC_WR,
  input wire logic I_CAN_PARALLEL_MAP,
  // port four registers for the shared pads
  input wire cips_pkg::cips_port_t I_PORT_FOUR,
  // pads
  input wire logic [cips_pkg::PIN_CNT-1:0] I_PIN_IN,
  output logic [cips_pkg::PIN_CNT-1:0] O_PIN_OUT,
  output logic [cips_pkg::PIN_CNT-1:0] O_PIN_OE,
  // can controllers
  input wire logic [1:0] I_CAN_TX,
  output logic [1:0] O_CAN_RX,
  input wire logic [1:0] I_CAN_IRQ,
  output logic [1:0] O_CAN_ACTIVE,
  // extension bus select and interrupts
  input wire logic I_XBUS_SEL,
  input wire logic [cips_pkg::ADDR_W-1:0] I_XBUS_ADDR,
  output logic [1:0] O_CAN_CS,
  input wire logic [cips_pkg::XIRQ_CNT-1:0] I_XPER_IRQ,
  output logic [cips_pkg::XIRQ_CNT-1:0] O_XBUS_IRQ,
  // i2c engine
  input wire logic I_I2C_SCL_DRV,
  input wire logic I_I2C_SDA_DRV,
  output logic O_I2C_SCL_IN,
  output logic O_I2C_SDA_IN,
  input wire cips_pkg::cips_i2c_irq_t I_I2C_IRQ,
  output cips_pkg::cips_i2c_irq_t O_I2C_IRQ,
  // status
  output cips_pkg::cips_perctl_t O_PERCTL,
  output logic O_CAN_PARALLEL_MAP,
  output logic [3:0] O_SEG_LINES,
  output logic [7:0] O_MEM_MBYTE,
  output logic [6:0] O_MSG_OBJ
);

  import cips_pkg::*;

  typedef struct packed {
    cips_perctl_t perctl;
    logic can_par;
    cips_pad_t pad;
    logic [1:0] can_rx;
    logic [1:0] can_act;
    logic scl_in;
    logic sda_in;
    cips_i2c_irq_t i2c_irq;
    logic [XIRQ_CNT-1:0] xirq;
    logic [1:0] can_cs;
    logic [3:0] seg_lines;
    logic [7:0] mem_mb;
    logic [6:0] msg_obj;
  } cips_st_t;

  localparam cips_st_t ST_RST = '{
    perctl: PERCTL_RST, can_par: 1'b0, pad: '0, can_rx: 2'b11, can_act: 2'b00,
    scl_in: 1'b1, sda_in: 1'b1, i2c_irq: '0, xirq: '0, can_cs: 2'b00,
    seg_lines: SEG_LINES_ALL, mem_mb: MEM_MBYTE_ALL, msg_obj: MSG_OBJ_NONE};

  cips_st_t st_r;
  cips_st_t st_nxt;
  logic [PIN_CNT-1:0] pin_s;
  logic [PIN_CNT-1:0] drv;
  logic [PIN_CNT-1:0] val;
  logic [PIN_CNT-1:0] od;
  logic [PIN_CNT-1:0] pad_out;
  logic [PIN_CNT-1:0] pad_oe;
  logic [1:0] can_on;
  logic second_can_ctrl_par;
  logic second_can_ctrl_own;
  logic tx_pin_six;
  logic cs_hit;

  ////////////////////////////////////////////////////////////////////////
  // pad input synchroniser and output cells

  cips_sync2 #(.W(PIN_CNT)) u_sync (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_d(I_PIN_IN),
    .o_q(pin_s)
  );

  for (genvar g = 0; g < PIN_CNT; g++) begin : g_pad
    cips_pad_cell u_cell (
      .i_drive(drv[g]),
      .i_val(val[g]),
      .i_od(od[g]),
      .o_out(pad_out[g]),
      .o_oe(pad_oe[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // pin routing

  always_comb begin
    can_on = st_r.perctl.can_en & {2{I_GLOBAL_ENABLE}};
    second_can_ctrl_par = can_on[1] & st_r.can_par;
    second_can_ctrl_own = can_on[1] & ~st_r.can_par;
    // low is dominant: the first controller, or the second in parallel mode, pulls the shared line
    tx_pin_six = (~can_on[0] | I_CAN_TX[0]) & (~second_can_ctrl_par | I_CAN_TX[1]);
    // default: ordinary port pins
    drv = I_PORT_FOUR.dir;
    val = I_PORT_FOUR.data;
    od = I_PORT_FOUR.od;
    if (can_on[0] | second_can_ctrl_par) begin
      drv[PIN_TX1] = 1'b1;
      val[PIN_TX1] = tx_pin_six;
    end
    if (second_can_ctrl_own) begin
      drv[PIN_SDA_TX2] = 1'b1;
      val[PIN_SDA_TX2] = I_CAN_TX[1];
    end
    if (st_r.perctl.i2c_en) begin
      drv[PIN_SCL_RX2] = 1'b1;
      val[PIN_SCL_RX2] = I_I2C_SCL_DRV;
      od[PIN_SCL_RX2] = 1'b1;
      drv[PIN_SDA_TX2] = 1'b1;
      val[PIN_SDA_TX2] = I_I2C_SDA_DRV;
      od[PIN_SDA_TX2] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    cs_hit = I_XBUS_SEL && (I_XBUS_ADDR[ADDR_W-1:CAN_SEL_BIT+1] == CAN_BASE[ADDR_W-1:CAN_SEL_BIT+1]);
    if (I_PERCTL_WR) begin
      st_nxt.perctl.i2c_en = I_PERCTL_DATA.i2c_en;
      st_nxt.perctl.misc_access = I_PERCTL_DATA.misc_access;
      // controller choice is frozen once the extension bus is enabled
      if (!I_GLOBAL_ENABLE) begin
        st_nxt.perctl.can_en = I_PERCTL_DATA.can_en;
      end
    end
    if (I_MISC_WR && st_r.perctl.misc_access && I_GLOBAL_ENABLE) begin
      st_nxt.can_par = I_CAN_PARALLEL_MAP;
    end
    st_nxt.pad.out = pad_out;
    st_nxt.pad.oe = pad_oe;
    // idle receivers see recessive
    st_nxt.can_rx[0] = can_on[0] ? pin_s[PIN_RX1] : 1'b1;
    st_nxt.can_rx[1] = 1'b1;
    if (second_can_ctrl_par) begin
      st_nxt.can_rx[1] = pin_s[PIN_RX1];
    end else if (can_on[1] && !st_r.perctl.i2c_en) begin
      st_nxt.can_rx[1] = pin_s[PIN_SCL_RX2];
    end
    st_nxt.can_act = can_on;
    st_nxt.scl_in = st_r.perctl.i2c_en ? pin_s[PIN_SCL_RX2] : 1'b1;
    st_nxt.sda_in = st_r.perctl.i2c_en ? pin_s[PIN_SDA_TX2] : 1'b1;
    st_nxt.i2c_irq = I_I2C_IRQ;
    st_nxt.xirq = I_XPER_IRQ;
    st_nxt.xirq[FIRST_CAN_CTRL_XIRQ] = I_XPER_IRQ[FIRST_CAN_CTRL_XIRQ] | (I_CAN_IRQ[0] & can_on[0]);
    st_nxt.xirq[SECOND_CAN_CTRL_XIRQ] = I_XPER_IRQ[SECOND_CAN_CTRL_XIRQ] | (I_CAN_IRQ[1] & can_on[1]);
    st_nxt.can_cs[0] = cs_hit & ~I_XBUS_ADDR[CAN_SEL_BIT] & can_on[0];
    st_nxt.can_cs[1] = cs_hit & I_XBUS_ADDR[CAN_SEL_BIT] & can_on[1];
    st_nxt.seg_lines = (|can_on) ? SEG_LINES_CAN : SEG_LINES_ALL;
    st_nxt.mem_mb = (|can_on) ? MEM_MBYTE_CAN : MEM_MBYTE_ALL;
    st_nxt.msg_obj = (&can_on) ? MSG_OBJ_BOTH : ((|can_on) ? MSG_OBJ_ONE : MSG_OBJ_NONE);
    if (I_RST) begin
      st_nxt = ST_RST;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign O_PIN_OUT = st_r.pad.out;
  assign O_PIN_OE = st_r.pad.oe;
  assign O_CAN_RX = st_r.can_rx;
  assign O_CAN_ACTIVE = st_r.can_act;
  assign O_CAN_CS = st_r.can_cs;
  assign O_XBUS_IRQ = st_r.xirq;
  assign O_I2C_SCL_IN = st_r.scl_in;
  assign O_I2C_SDA_IN = st_r.sda_in;
  assign O_I2C_IRQ = st_r.i2c_irq;
  assign O_PERCTL = st_r.perctl;
  assign O_CAN_PARALLEL_MAP = st_r.can_par;
  assign O_SEG_LINES = st_r.seg_lines;
  assign O_MEM_MBYTE = st_r.mem_mb;
  assign O_MSG_OBJ = st_r.msg_obj;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  property p_i2c_scl_od;
    st_r.perctl.i2c_en && !I_I2C_SCL_DRV |=> O_PIN_OE[PIN_SCL_RX2] && !O_PIN_OUT[PIN_SCL_RX2];
  endproperty
  a_i2c_scl_od: assert property (p_i2c_scl_od) else $error("scl not pulled low");

  property p_i2c_release;
    st_r.perctl.i2c_en && I_I2C_SDA_DRV |=> !O_PIN_OE[PIN_SDA_TX2];
  endproperty
  a_i2c_release: assert property (p_i2c_release) else $error("sda driven while released");

  property p_gpio_back;
    !st_r.perctl.i2c_en && I_PORT_FOUR.dir[PIN_SCL_RX2] && !I_PORT_FOUR.od[PIN_SCL_RX2]
      |=> O_PIN_OE[PIN_SCL_RX2] && O_PIN_OUT[PIN_SCL_RX2] == $past(I_PORT_FOUR.data[PIN_SCL_RX2]);
  endproperty
  a_gpio_back: assert property (p_gpio_back) else $error("pad four not under port control");

  property p_tx1;
    can_on[0] && !I_CAN_TX[0] |=> O_PIN_OE[PIN_TX1] && !O_PIN_OUT[PIN_TX1];
  endproperty
  a_tx1: assert property (p_tx1) else $error("first transmit not on pad six");

  property p_tx2;
    second_can_ctrl_own && !st_r.perctl.i2c_en && !I_CAN_TX[1] |=> O_PIN_OE[PIN_SDA_TX2] && !O_PIN_OUT[PIN_SDA_TX2];
  endproperty
  a_tx2: assert property (p_tx2) else $error("second transmit not on pad seven");

  property p_cs2;
    cs_hit && I_XBUS_ADDR[CAN_SEL_BIT] && can_on[1] |=> O_CAN_CS == 2'b10;
  endproperty
  a_cs2: assert property (p_cs2) else $error("second chip select wrong");

  property p_irq2;
    I_CAN_IRQ[1] && can_on[1] |=> O_XBUS_IRQ[SECOND_CAN_CTRL_XIRQ];
  endproperty
  a_irq2: assert property (p_irq2) else $error("second interrupt lost");

  property p_freeze;
    I_GLOBAL_ENABLE && I_PERCTL_WR |=> st_r.perctl.can_en == $past(st_r.perctl.can_en);
  endproperty
  a_freeze: assert property (p_freeze) else $error("can enable changed after global enable");

  property p_rst;
    disable iff (1'b0) I_RST |=> O_PERCTL.can_en == 2'b01;
  endproperty
  a_rst: assert property (p_rst) else $error("reset enables wrong");

  property p_seg;
    (|can_on) |=> O_SEG_LINES == SEG_LINES_CAN && O_MEM_MBYTE == MEM_MBYTE_CAN;
  endproperty
  a_seg: assert property (p_seg) else $error("segment lines not reduced");

  property p_msg;
    (&can_on) |=> O_MSG_OBJ == MSG_OBJ_BOTH;
  endproperty
  a_msg: assert property (p_msg) else $error("object count wrong");

  property p_od_tx;
    can_on[0] && !second_can_ctrl_par && I_CAN_TX[0] && I_PORT_FOUR.od[PIN_TX1] |=> !O_PIN_OE[PIN_TX1];
  endproperty
  a_od_tx: assert property (p_od_tx) else $error("open-drain transmit drives high");

  property p_par;
    can_on[0] && second_can_ctrl_par && !I_CAN_TX[1] |=> O_PIN_OE[PIN_TX1] && !O_PIN_OUT[PIN_TX1];
  endproperty
  a_par: assert property (p_par) else $error("parallel dominant lost");

  property p_misc;
    I_MISC_WR && !st_r.perctl.misc_access |=> st_r.can_par == $past(st_r.can_par);
  endproperty
  a_misc: assert property (p_misc) else $error("misc write without access enable");

  property p_i2c_irq;
    I_I2C_IRQ.err ##1 I_I2C_IRQ.rx |-> O_I2C_IRQ.err ##1 O_I2C_IRQ.rx;
  endproperty
  a_i2c_irq: assert property (p_i2c_irq) else $error("i2c request lines late");

  property p_par_rx;
    second_can_ctrl_par |=> O_CAN_RX[1] == $past(pin_s[PIN_RX1]);
  endproperty
  a_par_rx: assert property (p_par_rx) else $error("shared receive not fed");

  property p_rx2;
    second_can_ctrl_own && !st_r.perctl.i2c_en |=> O_CAN_RX[1] == $past(pin_s[PIN_SCL_RX2]);
  endproperty
  a_rx2: assert property (p_rx2) else $error("second receive not from pad four");

  property p_cs_miss;
    !cs_hit |=> O_CAN_CS == 2'b00;
  endproperty
  a_cs_miss: assert property (p_cs_miss) else $error("chip select outside can window");

  property p_rst_second;
    disable iff (1'b0) I_RST |=> !O_CAN_ACTIVE[1];
  endproperty
  a_rst_second: assert property (p_rst_second) else $error("second controller active after reset");

  c_i2c_on: cover property (st_r.perctl.i2c_en && O_PIN_OE[PIN_SDA_TX2]);
  c_par: cover property (second_can_ctrl_par && can_on[0] && !O_PIN_OUT[PIN_TX1] && O_PIN_OE[PIN_TX1]);
  c_both: cover property (O_MSG_OBJ == MSG_OBJ_BOTH);

endmodule

// file: logic/cips_pad_cell.sv
// output stage of one shared pad: push-pull or open-drain
// assumes the caller registers the result
module cips_pad_cell (
  // request
  input wire logic i_drive,
  input wire logic i_val,
  input wire logic i_od,
  // pad drive
  output logic o_out,
  output logic o_oe
);

  // open-drain only ever pulls low
  always_comb begin
    o_out = i_od ? 1'b0 : i_val;
    o_oe = i_drive & (~i_od | ~i_val);
  end

endmodule

// file: logic/cips_pkg.sv
// constants, carrier types and reset values of the port-four sharing block
// assumes one system clock and a synchronous active-high reset
//
// What this block does
// - i2c enable forces clock/data pins open-drain
// - enabled i2c ignores port four registers
// - i2c disabled returns pins to port control, except seven while the second controller (not parallel) transmits there
// - first controller: transmit pin six, receive five
// - second controller: transmit seven, receive four
// - same offsets, bit eight splits chip selects
// - controller interrupts join shared extension lines
// - reset: first controller on, second off
// - any controller active: four segment lines only
// - both controllers together give 64 objects
// - port open-drain bits make transmit pins open-drain
// - parallel bit maps both onto five/six
// - i2c raises error, transmit, receive lines
package cips_pkg;

  localparam int unsigned PIN_CNT = 4;
  // pad index within the shared group
  localparam int unsigned PIN_SCL_RX2 = 0;
  localparam int unsigned PIN_RX1 = 1;
  localparam int unsigned PIN_TX1 = 2;
  localparam int unsigned PIN_SDA_TX2 = 3;

  localparam int unsigned ADDR_W = 24;
  localparam int unsigned CAN_SEL_BIT = 8;
  localparam logic [ADDR_W-1:0] CAN_BASE_DEF = 24'hef0000;

  localparam int unsigned XIRQ_CNT = 4;
  localparam int unsigned FIRST_CAN_CTRL_XIRQ = 0;
  localparam int unsigned SECOND_CAN_CTRL_XIRQ = 1;

  localparam logic [3:0] SEG_LINES_CAN = 4'h4;
  localparam logic [3:0] SEG_LINES_ALL = 4'h8;
  localparam logic [7:0] MEM_MBYTE_CAN = 8'h05;
  localparam logic [7:0] MEM_MBYTE_ALL = 8'h10;
  localparam logic [6:0] MSG_OBJ_NONE = 7'h00;
  localparam logic [6:0] MSG_OBJ_ONE = 7'h20;
  localparam logic [6:0] MSG_OBJ_BOTH = 7'h40;

  typedef struct packed {
    logic misc_access;
    logic i2c_en;
    logic [1:0] can_en;
  } cips_perctl_t;

  localparam cips_perctl_t PERCTL_RST = '{misc_access: 1'b0, i2c_en: 1'b0, can_en: 2'b01};

  typedef struct packed {
    logic [PIN_CNT-1:0] data;
    logic [PIN_CNT-1:0] dir;
    logic [PIN_CNT-1:0] od;
  } cips_port_t;

  typedef struct packed {
    logic [PIN_CNT-1:0] out;
    logic [PIN_CNT-1:0] oe;
  } cips_pad_t;

  typedef struct packed {
    logic err;
    logic tx;
    logic rx;
  } cips_i2c_irq_t;

endpackage

// file: logic/cips_sync2.sv
// two-flop synchroniser for pad levels
// assumes inputs are asynchronous to the clock
module cips_sync2 #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // levels
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cips_sync_st_t;

  cips_sync_st_t st_r;
  cips_sync_st_t st_nxt;

  always_comb begin
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
    if (i_rst) begin
      st_nxt = '1;
    end
  end

  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  assign o_q = st_r.s2;

endmodule

// file: testbench/can_i2c_port_sharing_ctrl_test.sv
// self-checking bench of the port-four sharing block
// assumes the pad far side is cips_bus_model
module can_i2c_port_sharing_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cips_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic perctl_wr = 1'b0;
  cips_perctl_t perctl_data = '0;
  logic glob = 1'b0;
  logic misc_wr = 1'b0;
  logic par = 1'b0;
  cips_port_t port = '0;
  logic [3:0] pull_low = 4'h0;
  logic [1:0] can_tx = 2'h3;
  logic [1:0] can_irq = 2'h0;
  logic xsel = 1'b0;
  logic [23:0] xaddr = 24'h000000;
  logic [3:0] xirq = 4'h0;
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  cips_i2c_irq_t i2c_irq = '0;
  logic [3:0] pin_in, pin_out, pin_oe, xbus_irq, seg;
  logic [1:0] can_rx, can_act, can_cs;
  logic scl_in, sda_in, par_o;
  cips_i2c_irq_t i2c_irq_o;
  cips_perctl_t perctl_o;
  logic [7:0] mem;
  logic [6:0] msg;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  can_i2c_port_sharing_ctrl i_can_i2c_port_sharing_ctrl (
    .I_SYS_CLK(clk), .I_RST(rst), .I_PERCTL_WR(perctl_wr), .I_PERCTL_DATA(perctl_data),
    .I_GLOBAL_ENABLE(glob), .I_MISC_WR(misc_wr), .I_CAN_PARALLEL_MAP(par), .I_PORT_FOUR(port),
    .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .I_CAN_TX(can_tx), .O_CAN_RX(can_rx),
    .I_CAN_IRQ(can_irq), .O_CAN_ACTIVE(can_act), .I_XBUS_SEL(xsel), .I_XBUS_ADDR(xaddr),
    .O_CAN_CS(can_cs), .I_XPER_IRQ(xirq), .O_XBUS_IRQ(xbus_irq), .I_I2C_SCL_DRV(scl_drv),
    .I_I2C_SDA_DRV(sda_drv), .O_I2C_SCL_IN(scl_in), .O_I2C_SDA_IN(sda_in), .I_I2C_IRQ(i2c_irq),
    .O_I2C_IRQ(i2c_irq_o), .O_PERCTL(perctl_o), .O_CAN_PARALLEL_MAP(par_o), .O_SEG_LINES(seg),
    .O_MEM_MBYTE(mem), .O_MSG_OBJ(msg)
  );

  cips_bus_model i_cips_bus_model (.i_out(pin_out), .i_oe(pin_oe), .i_pull_low(pull_low), .o_level(pin_in));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr_perctl(input cips_perctl_t d);
    @(posedge clk);
    perctl_wr <= 1'b1;
    perctl_data <= d;
    @(posedge clk);
    perctl_wr <= 1'b0;
    settle(3);
  endtask

  task automatic misc_write(input logic v);
    @(posedge clk);
    misc_wr <= 1'b1;
    par <= v;
    @(posedge clk);
    misc_wr <= 1'b0;
    settle(3);
  endtask

  task automatic pull(input logic [3:0] v);
    @(posedge clk);
    pull_low <= v;
    settle(4);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      $display("timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk("perctl", 8'(perctl_o), 8'(PERCTL_RST));
    chk("seg", 8'(seg), 8'(SEG_LINES_ALL));
    misc_write(1'b1);
    chk("parallel", 8'(par_o), 8'h00);
    $display("test reset done");
    wr_perctl('{1'b1, 1'b0, 2'b11});
    misc_write(1'b1);
    chk("parallel", 8'(par_o), 8'h00);
    @(posedge clk);
    glob <= 1'b1;
    settle(3);
    chk("active", 8'(can_act), 8'h03);
    chk("seg", 8'(seg), 8'(SEG_LINES_CAN));
    chk("mem", mem, MEM_MBYTE_CAN);
    chk("msg", 8'(msg), 8'(MSG_OBJ_BOTH));
    wr_perctl('{1'b1, 1'b0, 2'b01});
    chk("can_en", 8'(perctl_o.can_en), 8'h03);
    $display("test enables done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      port <= '{4'h0, 4'h0, (k > 3) ? 4'hc : 4'h0};
      can_tx <= 2'(k);
      settle(3);
      chk("tx pads", 8'({pin_oe[3:2], pin_out[3:2]}), (k > 3) ? 8'({~2'(k), 2'b00}) : 8'({2'b11, 2'(k)}));
    end
    pull(4'h2);
    chk("rx", 8'(can_rx), 8'h02);
    pull(4'h1);
    chk("rx", 8'(can_rx), 8'h01);
    $display("test routing done");
    @(posedge clk);
    can_irq <= 2'b11;
    xirq <= 4'h8;
    settle(2);
    chk("xbus irq", 8'(xbus_irq), 8'h0b);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      xsel <= 1'b1;
      xaddr <= (k == 2) ? 24'h00012a : (CAN_BASE_DEF | 24'h00002a | ((k == 1) ? 24'h000100 : 24'h000000));
      settle(2);
      chk("cs", 8'(can_cs), (k == 2) ? 8'h00 : 8'(1 << k));
    end
    $display("test select done");
    @(posedge clk);
    port <= '{4'h8, 4'h8, 4'h0};
    misc_write(1'b1);
    chk("parallel", 8'(par_o), 8'h01);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      can_tx <= 2'(k);
      settle(3);
      chk("shared tx", 8'({pin_oe[3:2], pin_out[3:2]}), 8'({3'b111, &2'(k)}));
    end
    pull(4'h1);
    chk("rx", 8'(can_rx), 8'h03);
    pull(4'h2);
    chk("rx", 8'(can_rx), 8'h00);
    $display("test parallel done");
    @(posedge clk);
    port <= '{4'h9, 4'h9, 4'h0};
    scl_drv <= 1'b0;
    i2c_irq <= '{1'b1, 1'b0, 1'b1};
    wr_perctl('{1'b1, 1'b1, 2'b11});
    chk("i2c pads", 8'({pin_oe[3], pin_oe[0], pin_out[3], pin_out[0]}), 8'h04);
    chk("i2c irq", 8'(i2c_irq_o), 8'h05);
    pull(4'h8);
    chk("i2c in", 8'({scl_in, sda_in}), 8'h00);
    @(posedge clk);
    sda_drv <= 1'b0;
    settle(2);
    chk("i2c pads", 8'({pin_oe[3], pin_oe[0], pin_out[3], pin_out[0]}), 8'h0c);
    wr_perctl('{1'b1, 1'b0, 2'b11});
    chk("gpio pads", 8'({pin_oe[3], pin_oe[0], pin_out[3], pin_out[0]}), 8'h0f);
    chk("i2c in", 8'({scl_in, sda_in}), 8'h03);
    $display("test i2c done");
    tally_and_finish();
  end
endmodule

// file: testbench/cips_bus_model.sv
// far side of the four shared pads: transceiver and i2c devices
// assumes pull-ups on every pad; any party pulling low wins
module cips_bus_model
  import cips_pkg::*;
(
  // pad drive from the block
  input wire logic [cips_pkg::PIN_CNT-1:0] i_out,
  input wire logic [cips_pkg::PIN_CNT-1:0] i_oe,
  // far-side pull-down requests
  input wire logic [cips_pkg::PIN_CNT-1:0] i_pull_low,
  // resolved pad levels
  output logic [cips_pkg::PIN_CNT-1:0] o_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released pad floats to the pull-up level
  assign o_level = ~i_pull_low & (~i_oe | i_out);
endmodule
